/* sim/sfc_host.sv */
// host controller model driving the parameter port
`include "sfc_map.svh"
`default_nettype none
module sfc_host (
  input  wire logic        clk_sys,
  input  wire logic [15:0] par_rdata,
  output logic             par_wr, par_rd,
  output logic      [15:0] par_addr, par_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {par_wr, par_rd, par_addr, par_wdata} = '0;
  // one-cycle strobe, answer taken at the ack edge; reserved bits written as zero
  task automatic acc(input logic w, input logic [15:0] ad, d, output logic [15:0] q);
    @(posedge clk_sys);
    {par_wr, par_rd, par_addr} <= {w, !w, ad};
    par_wdata <= d & (ad == `SFC_ADDR_ONE ? `SFC_MASK_ONE : ad == `SFC_ADDR_TWO ? `SFC_MASK_TWO : 16'hFFFF);
    @(posedge clk_sys);
    {par_wr, par_rd} <= 2'b00;
    @(posedge clk_sys);
    q = par_rdata;
  endtask
endmodule // sfc_host
`default_nettype wire

/* sim/sfc_properties.sv */
// concurrent checks of fault gating at the special-function block ports
`include "sfc_map.svh"
`default_nettype none
module sfc_properties (
  input wire logic        clk_sys, reset, par_wr,
  input wire logic [15:0] par_addr, par_wdata,
  input wire logic        abnormal_pulse_raw, wiring_error_raw, wiring_cut_raw, phase_loss_raw,
  input wire logic        encoder_output_raw, undervoltage_raw, aux_fault_b_raw, feedback_fault_raw,
  input wire logic        external_pulse_position_mode, full_closed_loop, fault_clear,
  input wire logic        abnormal_pulse_fault, wiring_error_fault, wiring_cut_fault, supply_phase_loss_alarm,
  input wire logic        encoder_output_alarm, undervoltage_fault, auxiliary_fault_b, closed_loop_feedback_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] w1, w2;
  // shadow of both config words as written through the port
  always_ff @(posedge clk_sys) begin
    if (reset) {w1, w2} <= '0;
    else if (par_wr && par_addr == `SFC_ADDR_ONE) w1 <= par_wdata & `SFC_MASK_ONE;
    else if (par_wr && par_addr == `SFC_ADDR_TWO) w2 <= par_wdata & `SFC_MASK_TWO;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_ABN: assert property (abnormal_pulse_fault == $past(abnormal_pulse_raw && external_pulse_position_mode && !w1[6])) else $error("abnormal pulse gate");
  AST_WERR: assert property (wiring_error_raw && w1[8] |=> wiring_error_fault) else $error("miswire gate");
  AST_WCUT: assert property (wiring_cut_fault == $past(wiring_cut_raw && w1[9])) else $error("wire cut gate");
  AST_PHASE: assert property (phase_loss_raw && w1[12] |=> !supply_phase_loss_alarm) else $error("phase gate");
  AST_ENC: assert property (encoder_output_alarm == $past(encoder_output_raw && !w1[13])) else $error("encoder gate");
  AST_UV: assert property (undervoltage_fault == $past(undervoltage_raw || (undervoltage_fault && !(fault_clear || w2[2])))) else $error("uv latch");
  AST_AUX: assert property (auxiliary_fault_b == $past(aux_fault_b_raw && !w2[4])) else $error("aux gate");
  AST_FB: assert property (closed_loop_feedback_fault == $past(feedback_fault_raw && full_closed_loop && w2[5])) else $error("fb gate");
endmodule // sfc_properties
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the special-function block
`include "sfc_map.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset, wr, rd, sm, pt, fcl, ci, pv, pn, fc, sa, ta, pov, zc, pl, pb, st, ld, al, ev, ea, b11, b12;
  logic [15:0] a, wd, rdat, cmd, thr, fr, cmo, fro, q;
  logic [6:0] pins;
  logic [7:0] raw;
  logic [1:0] sc, tc;
  logic [31:0] s;
  int fails, comparisons, n;
  sfc_top #(.SETTLE_UNIT_CYCLES(4)) sfc_top_inst (.clk_sys, .reset, .par_wr(wr), .par_rd(rd), .par_addr(a),
    .par_wdata(wd), .par_rdata(rdat), .par_ack(), .speed_select_bit_a(pins[0]), .speed_select_bit_b(pins[1]),
    .torque_select_bit_a(pins[2]), .torque_select_bit_b(pins[3]), .zero_speed_hold_input(pins[4]),
    .negative_travel_limit(pins[5]), .positive_travel_limit(pins[6]), .speed_mode(sm), .full_closed_loop(fcl),
    .external_pulse_position_mode(pt), .cmd_is_internal(ci), .speed_cmd_in(cmd), .zero_speed_threshold(thr),
    .friction_comp_in(fr), .pulse_in_valid(pv), .pulse_in_negative(pn), .abnormal_pulse_raw(raw[0]),
    .wiring_error_raw(raw[1]), .wiring_cut_raw(raw[2]), .phase_loss_raw(raw[3]), .encoder_output_raw(raw[4]),
    .undervoltage_raw(raw[5]), .aux_fault_b_raw(raw[6]), .feedback_fault_raw(raw[7]), .fault_clear(fc),
    .semi_auto_tuning(sa), .tuning_adjusting(ta), .speed_sel_code(sc), .speed_sel_load(ld), .torque_sel_code(tc),
    .torque_sel_load(), .zero_clamp_active(zc), .position_lock(pl), .profile_bypass(pb), .speed_cmd_out(cmo),
    .friction_comp_out(fro), .pulse_out_valid(pov), .pulse_out_negative(), .abnormal_pulse_fault(),
    .wiring_error_fault(), .wiring_cut_fault(), .supply_phase_loss_alarm(al), .encoder_output_alarm(),
    .undervoltage_fault(), .auxiliary_fault_b(), .closed_loop_feedback_fault(), .inertia_stable(st));
  sfc_host sfc_host_inst (.clk_sys, .par_rdata(rdat), .par_wr(wr), .par_rd(rd), .par_addr(a), .par_wdata(wd));
  function automatic logic [31:0] lf(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic ck(input logic [15:0] g, e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [15:0] ad, e);
    sfc_host_inst.acc(1'b0, ad, 16'h0000, q);
    ck(q, e);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge clk_sys);
    fails++;
    end_of_test();
  end
  // main sequence
  initial begin
    reset = 1'b1;
    {sm, pt, fcl, ci, pv, pn, fc, sa, ta, pins, raw, cmd, thr, fr} = '0;
    s = 32'h00014E42;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    rc(`SFC_ADDR_ONE, `SFC_RESET_ONE);
    rc(`SFC_ADDR_TWO, `SFC_RESET_TWO);
    rc(`SFC_ADDR_SETTLE, `SFC_RESET_SETTLE);
    sfc_host_inst.acc(1'b1, `SFC_ADDR_SETTLE, 16'h0BB8, q);
    rc(`SFC_ADDR_SETTLE, `SFC_SETTLE_MAX);
    rc(16'h0300, 16'h0000);
    pins <= 7'h05;
    repeat (8) @(posedge clk_sys);
    ck({tc, sc, ld}, 16'h000B);
    sfc_host_inst.acc(1'b1, `SFC_ADDR_ONE, 16'h0003, q);
    n = 0;
    pins <= 7'h0F;
    repeat (10) @(posedge clk_sys) n += ld;
    ck(16'(n), 16'h0001);
    ck({tc, sc}, 16'h000F);
    // falling select bits must not reload the codes in edge mode
    pins <= 7'h05;
    repeat (8) @(posedge clk_sys);
    ck({tc, sc}, 16'h000F);
    sfc_host_inst.acc(1'b1, `SFC_ADDR_ONE, 16'h0000, q);
    {sm, cmd, thr, fr, pins} <= {1'b1, 16'h0005, 16'h000A, 16'h0007, 7'h10};
    repeat (8) @(posedge clk_sys);
    ck({zc, pl, pb}, 16'h0007);
    ci <= 1'b1;
    repeat (2) @(posedge clk_sys);
    ck({pl, pb}, 16'h0002);
    // lift the command above threshold so friction picks up a value, then hold it
    cmd <= 16'h0020;
    @(posedge clk_sys);
    cmd <= 16'h0005;
    repeat (2) @(posedge clk_sys);
    ck(fro, 16'h0007);
    sfc_host_inst.acc(1'b1, `SFC_ADDR_ONE, 16'h8400, q);
    repeat (2) @(posedge clk_sys);
    ck(cmo, 16'h0000);
    ck(fro, 16'h0000);
    // analog source with ramping on: one step down from the followed command
    {ci, cmd} <= {1'b0, 16'h0035};
    @(posedge clk_sys);
    thr <= 16'h0100;
    repeat (2) @(posedge clk_sys);
    ck(cmo, 16'h0035 - `SFC_RAMP_STEP);
    {pt, sm} <= 2'b10;
    repeat (8) begin
      s = lf(s);
      {b12, b11} = s[12:11];
      sfc_host_inst.acc(1'b1, `SFC_ADDR_ONE, s[15:0], q);
      sfc_host_inst.acc(1'b1, `SFC_ADDR_TWO, s[31:16], q);
      pins[6:5] <= s[30:29];
      for (n = 0; n < 40; n++) begin
        @(posedge clk_sys);
        if (n > 6) ck(pov, ev);
        if (n > 6) ck(al, ea);
        ev = pv & !(b11 & ((pn & pins[5]) | (!pn & pins[6])));
        ea = raw[3] & !b12;
        s = lf(s);
        {raw, pv, pn, fc, fcl, pins[3:2]} <= s[13:0];
      end
    end
    sfc_host_inst.acc(1'b1, `SFC_ADDR_SETTLE, 16'h0002, q);
    {sa, ta} <= 2'b11;
    repeat (8) @(posedge clk_sys);
    ck(st, 16'h0000);
    repeat (6) @(posedge clk_sys);
    ck(st, 16'h0001);
    end_of_test();
  end
endmodule // tb_top
bind sfc_top sfc_properties sfc_properties_inst (.*);
`default_nettype wire

/* src/sfc_map.svh */
// register offsets, field positions, reset values and timing counts of the special-function block
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH

// ----------------------------------------------------------------------------
// parameter word addresses
// ----------------------------------------------------------------------------
`define SFC_ADDR_ONE            16'h0282
`define SFC_ADDR_TWO            16'h0284
`define SFC_ADDR_SETTLE         16'h0286

// ----------------------------------------------------------------------------
// reset values and the settle-time maximum
// ----------------------------------------------------------------------------
`define SFC_RESET_ONE           16'h0000
`define SFC_RESET_TWO           16'h0000
`define SFC_RESET_SETTLE        16'h000F
`define SFC_SETTLE_MAX          16'h07D0

// ----------------------------------------------------------------------------
// writable field masks (reserved bits are not stored and read as zero)
// ----------------------------------------------------------------------------
`define SFC_MASK_ONE            16'hBF43
`define SFC_MASK_TWO            16'h0034

// ----------------------------------------------------------------------------
// first word fields
// ----------------------------------------------------------------------------
`define SFC_ONE_SPEED_EDGE      0
`define SFC_ONE_TORQUE_EDGE     1
`define SFC_ONE_PULSE_CHK_OFF   6
`define SFC_ONE_WIRE_ERR_ON     8
`define SFC_ONE_WIRE_CUT_ON     9
`define SFC_ONE_CLAMP_RAMP      10
`define SFC_ONE_LIMIT_INHIBIT   11
`define SFC_ONE_PHASE_CHK_OFF   12
`define SFC_ONE_ENC_CHK_OFF     13
`define SFC_ONE_FRIC_ZERO       15

// ----------------------------------------------------------------------------
// second word fields
// ----------------------------------------------------------------------------
`define SFC_TWO_UV_AUTO_CLR     2
`define SFC_TWO_AUX_B_OFF       4
`define SFC_TWO_FB_REPORT       5

// ----------------------------------------------------------------------------
// synchronised pin positions
// ----------------------------------------------------------------------------
`define SFC_PIN_SPD_A           0
`define SFC_PIN_SPD_B           1
`define SFC_PIN_TRQ_A           2
`define SFC_PIN_TRQ_B           3
`define SFC_PIN_ZERO_SPEED_HOLD_INPUT          4
`define SFC_PIN_NEG_LIM         5
`define SFC_PIN_POS_LIM         6
`define SFC_PIN_COUNT           7

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SFC_CLK_MHZ             250
`define SFC_SETTLE_UNIT_US      100000
`define SFC_SETTLE_UNIT_CYCLES  (`SFC_SETTLE_UNIT_US * `SFC_CLK_MHZ)
`define SFC_RAMP_STEP           16'h0010

`endif

/* src/sfc_pin_if.sv */
// carrier for synchronised pin levels and their rising edges
`default_nettype none

interface sfc_pin_if;
  logic [6:0] level;
  logic [6:0] rise;

  modport source (output level, output rise);
  modport sink   (input level, input rise);
endinterface : sfc_pin_if

`default_nettype wire

/* src/sfc_pin_sync.sv */
// three-stage synchroniser and rising-edge detector for the discrete inputs
`include "sfc_map.svh"
`default_nettype none

module sfc_pin_sync
  import sfc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [6:0] pins,
  sfc_pin_if.source       pin_bus
);

  logic [6:0] stage_a;
  logic [6:0] stage_b;
  logic [6:0] stage_c;
  logic [6:0] level;
  logic [6:0] level_prev;

  // ----------------------------------------------------------------------------
  // per pin: three flops, accept a change once stages two and three agree
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < `SFC_PIN_COUNT; i++) begin : g_pin
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        stage_a[i]    <= 1'b0;
        stage_b[i]    <= 1'b0;
        stage_c[i]    <= 1'b0;
        level[i]      <= 1'b0;
        level_prev[i] <= 1'b0;
      end else begin
        stage_a[i]    <= pins[i];
        stage_b[i]    <= stage_a[i];
        stage_c[i]    <= stage_b[i];
        if (stage_b[i] == stage_c[i]) begin
          level[i] <= stage_c[i];
        end
        level_prev[i] <= level[i];
      end
    end

    // one-cycle flag when the last sample was low and this one is high
    assign pin_bus.rise[i] = level[i] & ~level_prev[i];
  end

  assign pin_bus.level = level;

endmodule : sfc_pin_sync

`default_nettype wire

/* src/sfc_pkg.sv */
// types shared by the special-function configuration block
`default_nettype none

package sfc_pkg;

  // inertia settle sequencer, gray coded along idle -> adjust -> stable
  typedef enum logic [1:0] {
    SFC_TUNE_IDLE   = 2'b00,
    SFC_TUNE_ADJUST = 2'b01,
    SFC_TUNE_STABLE = 2'b11
  } sfc_tune_state_type;

  typedef logic [15:0] sfc_word_type;

endpackage : sfc_pkg

`default_nettype wire

/* src/sfc_top.sv */
// special-function parameter words, select triggering, fault gating, zero clamp and inertia settle
`include "sfc_map.svh"
`default_nettype none

// Operation
// - speed select: level, or rising edge when set
// - torque select: level, or rising edge when set
// - abnormal pulse check in pulse mode unless disabled
// - miswiring check only when enabled
// - broken-wire check only when enabled
// - clamp needs speed mode, input, low command
// - analog, ramp off: lock position, no profile
// - internal, ramp off: lock, keep profile
// - analog, ramp on: ramp to zero
// - internal, ramp on: force zero immediately
// - inhibit off: accept all position pulses
// - inhibit on, pulse mode: block pulses toward active limit
// - inhibit on, pulse mode, both limits active: block both directions
// - phase loss alarm unless disabled
// - encoder output alarm unless disabled
// - low speed: friction holds or zeroes
// - undervoltage auto-clear or stays latched
// - auxiliary fault suppressed when bit set
// - closed-loop feedback fault reported in full closed loop when bit set
// - inertia stable after settle time adjusting
module sfc_top
  import sfc_pkg::*;
#(
  parameter int unsigned SETTLE_UNIT_CYCLES = `SFC_SETTLE_UNIT_CYCLES
)
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // parameter access port
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [15:0] par_addr,
  input  wire logic [15:0] par_wdata,
  output logic      [15:0] par_rdata,
  output logic             par_ack,
  // discrete inputs (asynchronous pins)
  input  wire logic        speed_select_bit_a,
  input  wire logic        speed_select_bit_b,
  input  wire logic        torque_select_bit_a,
  input  wire logic        torque_select_bit_b,
  input  wire logic        zero_speed_hold_input,
  input  wire logic        negative_travel_limit,
  input  wire logic        positive_travel_limit,
  // drive state from logic on the same clock
  input  wire logic        speed_mode,
  input  wire logic        external_pulse_position_mode,
  input  wire logic        full_closed_loop,
  input  wire logic        cmd_is_internal,
  input  wire logic [15:0] speed_cmd_in,
  input  wire logic [15:0] zero_speed_threshold,
  input  wire logic [15:0] friction_comp_in,
  input  wire logic        pulse_in_valid,
  input  wire logic        pulse_in_negative,
  // raw detector outputs
  input  wire logic        abnormal_pulse_raw,
  input  wire logic        wiring_error_raw,
  input  wire logic        wiring_cut_raw,
  input  wire logic        phase_loss_raw,
  input  wire logic        encoder_output_raw,
  input  wire logic        undervoltage_raw,
  input  wire logic        aux_fault_b_raw,
  input  wire logic        feedback_fault_raw,
  input  wire logic        fault_clear,
  // tuning
  input  wire logic        semi_auto_tuning,
  input  wire logic        tuning_adjusting,
  // results
  output logic      [1:0]  speed_sel_code,
  output logic             speed_sel_load,
  output logic      [1:0]  torque_sel_code,
  output logic             torque_sel_load,
  output logic             zero_clamp_active,
  output logic             position_lock,
  output logic             profile_bypass,
  output logic      [15:0] speed_cmd_out,
  output logic      [15:0] friction_comp_out,
  output logic             pulse_out_valid,
  output logic             pulse_out_negative,
  output logic             abnormal_pulse_fault,
  output logic             wiring_error_fault,
  output logic             wiring_cut_fault,
  output logic             supply_phase_loss_alarm,
  output logic             encoder_output_alarm,
  output logic             undervoltage_fault,
  output logic             auxiliary_fault_b,
  output logic             closed_loop_feedback_fault,
  output logic             inertia_stable
);

  // ----------------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------------
  sfc_pin_if pin_bus ();

  wire logic [6:0] pin_vec = {positive_travel_limit, negative_travel_limit, zero_speed_hold_input,
                              torque_select_bit_b, torque_select_bit_a,
                              speed_select_bit_b, speed_select_bit_a};

  sfc_pin_sync u_pin_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pins    (pin_vec),
    .pin_bus (pin_bus.source)
  );

  // ----------------------------------------------------------------------------
  // parameter words
  // ----------------------------------------------------------------------------
  sfc_word_type special_function_one_cfg;
  sfc_word_type special_function_two_cfg;
  sfc_word_type inertia_settle_time;

  // address decode
  wire logic hit_one    = (par_addr == `SFC_ADDR_ONE);
  wire logic hit_two    = (par_addr == `SFC_ADDR_TWO);
  wire logic hit_settle = (par_addr == `SFC_ADDR_SETTLE);

  // reserved bits are dropped on write so they always read back as zero
  wire sfc_word_type next_one    = par_wdata & `SFC_MASK_ONE;
  wire sfc_word_type next_two    = par_wdata & `SFC_MASK_TWO;
  wire sfc_word_type next_settle = (par_wdata > `SFC_SETTLE_MAX) ? `SFC_SETTLE_MAX : par_wdata;

  wire sfc_word_type read_mux = hit_one    ? special_function_one_cfg :
                                hit_two    ? special_function_two_cfg :
                                hit_settle ? inertia_settle_time : 16'h0000;

  // word writes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      special_function_one_cfg <= `SFC_RESET_ONE;
      special_function_two_cfg <= `SFC_RESET_TWO;
      inertia_settle_time      <= `SFC_RESET_SETTLE;
    end else if (par_wr) begin
      if (hit_one)    special_function_one_cfg <= next_one;
      if (hit_two)    special_function_two_cfg <= next_two;
      if (hit_settle) inertia_settle_time      <= next_settle;
    end
  end

  // one-cycle acknowledge for any access; unmapped reads return zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      par_ack   <= 1'b0;
      par_rdata <= 16'h0000;
    end else begin
      par_ack   <= par_wr | par_rd;
      par_rdata <= par_rd ? read_mux : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------------------
  wire logic speed_edge    = special_function_one_cfg[`SFC_ONE_SPEED_EDGE];
  wire logic torque_edge   = special_function_one_cfg[`SFC_ONE_TORQUE_EDGE];
  wire logic pulse_chk_off = special_function_one_cfg[`SFC_ONE_PULSE_CHK_OFF];
  wire logic wire_err_on   = special_function_one_cfg[`SFC_ONE_WIRE_ERR_ON];
  wire logic wire_cut_on   = special_function_one_cfg[`SFC_ONE_WIRE_CUT_ON];
  wire logic clamp_ramp    = special_function_one_cfg[`SFC_ONE_CLAMP_RAMP];
  wire logic limit_inhibit = special_function_one_cfg[`SFC_ONE_LIMIT_INHIBIT];
  wire logic phase_chk_off = special_function_one_cfg[`SFC_ONE_PHASE_CHK_OFF];
  wire logic enc_chk_off   = special_function_one_cfg[`SFC_ONE_ENC_CHK_OFF];
  wire logic fric_zero     = special_function_one_cfg[`SFC_ONE_FRIC_ZERO];
  wire logic uv_auto_clr   = special_function_two_cfg[`SFC_TWO_UV_AUTO_CLR];
  wire logic aux_b_off     = special_function_two_cfg[`SFC_TWO_AUX_B_OFF];
  wire logic fb_report     = special_function_two_cfg[`SFC_TWO_FB_REPORT];

  // ----------------------------------------------------------------------------
  // select inputs: follow the level, or load only on a rising edge of either bit
  // ----------------------------------------------------------------------------
  wire logic [1:0] speed_level  = {pin_bus.level[`SFC_PIN_SPD_B], pin_bus.level[`SFC_PIN_SPD_A]};
  wire logic [1:0] torque_level = {pin_bus.level[`SFC_PIN_TRQ_B], pin_bus.level[`SFC_PIN_TRQ_A]};
  wire logic speed_rise  = pin_bus.rise[`SFC_PIN_SPD_A] | pin_bus.rise[`SFC_PIN_SPD_B];
  wire logic torque_rise = pin_bus.rise[`SFC_PIN_TRQ_A] | pin_bus.rise[`SFC_PIN_TRQ_B];
  wire logic speed_take  = speed_edge ? speed_rise : 1'b1;
  wire logic torque_take = torque_edge ? torque_rise : 1'b1;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      speed_sel_code  <= 2'h0;
      speed_sel_load  <= 1'b0;
      torque_sel_code <= 2'h0;
      torque_sel_load <= 1'b0;
    end else begin
      speed_sel_load  <= speed_take;
      torque_sel_load <= torque_take;
      if (speed_take)  speed_sel_code  <= speed_level;
      if (torque_take) torque_sel_code <= torque_level;
    end
  end

  // ----------------------------------------------------------------------------
  // zero clamp and speed command shaping
  // ----------------------------------------------------------------------------
  wire logic [15:0] speed_mag  = speed_cmd_in[15] ? (16'h0000 - speed_cmd_in) : speed_cmd_in;
  wire logic        below_zero = (speed_mag < zero_speed_threshold);
  wire logic        clamp_cond = speed_mode & pin_bus.level[`SFC_PIN_ZERO_SPEED_HOLD_INPUT] & below_zero;

  // position lock applies only with ramping off; analog source drops its profile
  wire logic next_lock   = clamp_cond & ~clamp_ramp;
  wire logic next_bypass = clamp_cond & ~clamp_ramp & ~cmd_is_internal;

  // one step of the ramp toward zero, never crossing it
  wire logic [15:0] out_mag   = speed_cmd_out[15] ? (16'h0000 - speed_cmd_out) : speed_cmd_out;
  wire logic        ramp_last = (out_mag <= `SFC_RAMP_STEP);
  wire logic [15:0] ramp_down = speed_cmd_out[15] ? (speed_cmd_out + `SFC_RAMP_STEP)
                                                  : (speed_cmd_out - `SFC_RAMP_STEP);
  wire logic [15:0] ramp_val  = ramp_last ? 16'h0000 : ramp_down;

  // clamp with ramping on: internal source jumps to zero, analog ramps down
  wire logic [15:0] next_speed = (clamp_cond & clamp_ramp & cmd_is_internal)  ? 16'h0000 :
                                 (clamp_cond & clamp_ramp & ~cmd_is_internal) ? ramp_val :
                                 speed_cmd_in;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      zero_clamp_active <= 1'b0;
      position_lock     <= 1'b0;
      profile_bypass    <= 1'b0;
      speed_cmd_out     <= 16'h0000;
    end else begin
      zero_clamp_active <= clamp_cond;
      position_lock     <= next_lock;
      profile_bypass    <= next_bypass;
      speed_cmd_out     <= next_speed;
    end
  end

  // ----------------------------------------------------------------------------
  // friction compensation below zero speed: hold or zero
  // ----------------------------------------------------------------------------
  wire logic [15:0] next_fric = ~below_zero ? friction_comp_in :
                                fric_zero   ? 16'h0000 : friction_comp_out;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      friction_comp_out <= 16'h0000;
    end else begin
      friction_comp_out <= next_fric;
    end
  end

  // ----------------------------------------------------------------------------
  // position pulse inhibit by travel limits
  // ----------------------------------------------------------------------------
  wire logic neg_lim     = pin_bus.level[`SFC_PIN_NEG_LIM];
  wire logic pos_lim     = pin_bus.level[`SFC_PIN_POS_LIM];
  // a pulse is blocked toward an active limit; both active blocks both ways
  wire logic pulse_block = limit_inhibit & external_pulse_position_mode &
                           ((pulse_in_negative & neg_lim) | (~pulse_in_negative & pos_lim));
  wire logic next_pulse  = pulse_in_valid & ~pulse_block;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pulse_out_valid    <= 1'b0;
      pulse_out_negative <= 1'b0;
    end else begin
      pulse_out_valid    <= next_pulse;
      pulse_out_negative <= pulse_in_negative;
    end
  end

  // ----------------------------------------------------------------------------
  // detector gating
  // ----------------------------------------------------------------------------
  wire logic next_abn   = external_pulse_position_mode & ~pulse_chk_off & abnormal_pulse_raw;
  wire logic next_werr  = wire_err_on & wiring_error_raw;
  wire logic next_wcut  = wire_cut_on & wiring_cut_raw;
  wire logic next_phase = ~phase_chk_off & phase_loss_raw;
  wire logic next_enc   = ~enc_chk_off & encoder_output_raw;
  wire logic next_auxb  = ~aux_b_off & aux_fault_b_raw;
  wire logic next_fb    = full_closed_loop & fb_report & feedback_fault_raw;

  // undervoltage latch: a new event beats any clear in the same cycle
  wire logic uv_clear = fault_clear | uv_auto_clr;
  wire logic next_uv  = undervoltage_raw | (undervoltage_fault & ~uv_clear);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      abnormal_pulse_fault       <= 1'b0;
      wiring_error_fault         <= 1'b0;
      wiring_cut_fault           <= 1'b0;
      supply_phase_loss_alarm    <= 1'b0;
      encoder_output_alarm       <= 1'b0;
      auxiliary_fault_b          <= 1'b0;
      closed_loop_feedback_fault <= 1'b0;
      undervoltage_fault         <= 1'b0;
    end else begin
      abnormal_pulse_fault       <= next_abn;
      wiring_error_fault         <= next_werr;
      wiring_cut_fault           <= next_wcut;
      supply_phase_loss_alarm    <= next_phase;
      encoder_output_alarm       <= next_enc;
      auxiliary_fault_b          <= next_auxb;
      closed_loop_feedback_fault <= next_fb;
      undervoltage_fault         <= next_uv;
    end
  end

  // ----------------------------------------------------------------------------
  // inertia settle timer: units of one tenth, restarted if adjusting stops
  // ----------------------------------------------------------------------------
  sfc_tune_state_type tune_state;
  sfc_tune_state_type next_tune_state;
  logic [31:0]        unit_cnt;
  logic [15:0]        tenth_cnt;

  wire logic running   = semi_auto_tuning & tuning_adjusting;
  wire logic unit_tick = (unit_cnt >= (SETTLE_UNIT_CYCLES - 32'd1));
  wire logic settled   = (tenth_cnt >= inertia_settle_time);

  // next state of the settle sequencer
  always_comb begin
    next_tune_state = tune_state;
    case (tune_state)
      SFC_TUNE_IDLE: begin
        if (running) next_tune_state = SFC_TUNE_ADJUST;
      end
      SFC_TUNE_ADJUST: begin
        if (!running)     next_tune_state = SFC_TUNE_IDLE;
        else if (settled) next_tune_state = SFC_TUNE_STABLE;
      end
      SFC_TUNE_STABLE: begin
        if (!semi_auto_tuning) next_tune_state = SFC_TUNE_IDLE;
      end
      default: next_tune_state = SFC_TUNE_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tune_state     <= SFC_TUNE_IDLE;
      unit_cnt       <= 32'h0000_0000;
      tenth_cnt      <= 16'h0000;
      inertia_stable <= 1'b0;
    end else begin
      tune_state     <= next_tune_state;
      inertia_stable <= (next_tune_state == SFC_TUNE_STABLE);
      if (tune_state != SFC_TUNE_ADJUST || !running) begin
        unit_cnt  <= 32'h0000_0000;
        tenth_cnt <= 16'h0000;
      end else if (unit_tick) begin
        unit_cnt  <= 32'h0000_0000;
        tenth_cnt <= tenth_cnt + 16'h0001;
      end else begin
        unit_cnt  <= unit_cnt + 32'h0000_0001;
      end
    end
  end

endmodule : sfc_top

`default_nettype wire
